// *** tev_core_model.sv ***
// Timer core and DMA controller model feeding events into the control block
module tev_core_model
    import tev_pkg::*;
(
    // Clock
    input  wire logic   ref_clk,
    // Towards the control block
    output tev_evt_s    evt,
    output tev_dma_in_s dma_in,
    output logic        irq_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        evt = '0;
        dma_in = '0;
        irq_ack = 1'b0;
    end

    // One-cycle event pulses, as the counter logic makes them
    task automatic fire(input tev_evt_s v);
        @(posedge ref_clk);
        evt <= v;
        @(posedge ref_clk);
        evt <= '0;
    endtask

    // End of block from the DMA controller, one cycle
    task automatic end_block(input logic cap, input logic swap);
        @(posedge ref_clk);
        dma_in.eob_cap <= cap;
        dma_in.eob_cmp <= !cap;
        dma_in.swap_en <= swap;
        @(posedge ref_clk);
        dma_in.eob_cap <= 1'b0;
        dma_in.eob_cmp <= 1'b0;
    endtask

    // Core acknowledge of the group on the vector, one cycle
    task automatic ack;
        @(posedge ref_clk);
        irq_ack <= 1'b1;
        @(posedge ref_clk);
        irq_ack <= 1'b0;
    endtask
endmodule

// *** tev_ctrl.sv ***
// Event, flag, interrupt and DMA control section of the multi-function timer
//
// Chosen here: the Avalon-MM slave port.

module tev_ctrl
    import tev_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]     avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [DATA_W-1:0]     avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [DATA_W-1:0]     avs_readdata,
    output logic                       avs_waitrequest,
    // Timer core events
    input  wire tev_evt_s              evt,
    input  wire logic                  bicapture_mode,
    input  wire tev_dma_in_s           dma_in,
    input  wire logic                  irq_ack,
    // Pins and core outputs
    output logic                       output_pin_b,
    output logic                       chip_event_pulse,
    output logic                       irq_req,
    output logic      [7:0]            irq_vector,
    output logic                       sw_capture1_pulse,
    output logic                       sw_capture2_pulse,
    output tev_dma_out_s               dma_out
);

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction

    function automatic logic apply_action(input logic pin, input logic [1:0] code);
        case (code)
            ACT_SET:    apply_action = 1'b1;
            ACT_TOGGLE: apply_action = ~pin;
            ACT_CLEAR:  apply_action = 1'b0;
            default:    apply_action = pin;
        endcase
    endfunction

    logic        wait_q;
    logic [DATA_W-1:0] rdata_q;
    logic [7:0]  obc_q;
    logic [7:0]  flg_q;
    logic [7:0]  msk_q;
    logic [7:0]  dcp_q;
    logic [7:0]  dap_q;
    logic [4:0]  vbase_q;
    tev_grp_e    grp_q;
    logic        pin_q;
    logic        evp_q;
    logic        irq_q;
    logic        swc1_q;
    logic        swc2_q;
    logic        eob_cap_q;
    logic        eob_cmp_q;
    logic        dreq_cap_q;
    logic        dreq_cmp_q;
    logic        wr_go;
    logic        wr_obc;
    logic        wr_flg;
    logic        wr_msk;
    logic        wr_dcp;
    logic        wr_dap;
    logic        wr_vec;
    logic [7:0]  wd;
    logic [7:0]  rmux;
    logic [1:0]  act;
    logic        any_evt;
    logic        sw_cap1;
    logic        sw_cap2;
    logic        cap_src;
    logic        cmp_src;
    logic        cap_irq;
    logic        cmp_irq;
    logic        wrap_irq;
    logic [7:0]  flg_set;
    logic [7:0]  flg_keep;

    // Bus: waitrequest drops one cycle after a request, transfer ends on that edge
    assign wr_go  = avs_write & ~wait_q & avs_byteenable[0];
    assign wd     = avs_writedata[7:0];
    assign wr_obc = wr_go & (avs_address == byte_addr(IDX_OUTB_ACTION));
    assign wr_flg = wr_go & (avs_address == byte_addr(IDX_EVENT_FLAGS));
    assign wr_msk = wr_go & (avs_address == byte_addr(IDX_IRQ_DMA_MASKS));
    assign wr_dcp = wr_go & (avs_address == byte_addr(IDX_DMA_COUNT_PTR));
    assign wr_dap = wr_go & (avs_address == byte_addr(IDX_DMA_ADDR_PTR));
    assign wr_vec = wr_go & (avs_address == byte_addr(IDX_VECTOR_BASE));

    always_comb begin
        if (avs_address == byte_addr(IDX_OUTB_ACTION)) begin
            rmux = {obc_q[7:1], pin_q};
        end else if (avs_address == byte_addr(IDX_EVENT_FLAGS)) begin
            rmux = flg_q;
        end else if (avs_address == byte_addr(IDX_IRQ_DMA_MASKS)) begin
            rmux = msk_q;
        end else if (avs_address == byte_addr(IDX_DMA_COUNT_PTR)) begin
            rmux = dcp_q;
        end else if (avs_address == byte_addr(IDX_DMA_ADDR_PTR)) begin
            rmux = dap_q;
        end else if (avs_address == byte_addr(IDX_VECTOR_BASE)) begin
            rmux = {vbase_q, grp_q, 1'b0};
        end else begin
            rmux = 8'h00;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            if ((avs_read | avs_write) & wait_q) begin
                wait_q <= 1'b0;
            end else begin
                wait_q <= 1'b1;
            end
            if (avs_read & wait_q) begin
                rdata_q <= {24'h00_0000, rmux};
            end
        end
    end

    // Pin B actions
    always_comb begin
        act = ACT_NOP;
        if (evt.cmp1) begin
            act = act & obc_q[OB_C0_LO+:2];
        end
        if (evt.cmp2) begin
            act = act & obc_q[OB_C1_LO+:2];
        end
        if (evt.wrap) begin
            act = act & obc_q[OB_WR_LO+:2];
        end
    end
    assign any_evt = evt.cmp1 | evt.cmp2 | evt.wrap;

    // Hardware action wins over a preset written in the same cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pin_q <= RST_OUTB_ACTION[OB_PRE];
        end else if (any_evt) begin
            pin_q <= apply_action(pin_q, act);
        end else if (wr_obc) begin
            pin_q <= wd[OB_PRE];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            obc_q <= RST_OUTB_ACTION;
        end else if (wr_obc) begin
            obc_q <= wd;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            evp_q <= 1'b0;
        end else begin
            evp_q <= evt.wrap & obc_q[OB_OEV];
        end
    end

    // Flags: hardware set wins over a software clear in the same cycle
    assign sw_cap1 = wr_flg & wd[FL_CAP1];
    assign sw_cap2 = wr_flg & wd[FL_CAP2] & ~bicapture_mode;
    always_comb begin
        flg_set           = 8'h00;
        flg_set[FL_CAP1]  = evt.cap1 | sw_cap1;
        flg_set[FL_CAP2]  = evt.cap2 | sw_cap2;
        flg_set[FL_CMP1]  = evt.cmp1;
        flg_set[FL_CMP2]  = evt.cmp2;
        flg_set[FL_WRAP]  = evt.wrap;
        flg_set[FL_OCAP]  = (evt.cap1 & flg_q[FL_CAP1]) | sw_cap1;
        flg_set[FL_OCMP]  = evt.cmp1 & flg_q[FL_CMP1];
        flg_keep          = wr_flg ? wd : 8'hff;
        flg_keep[FL_COMB] = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flg_q <= RST_EVENT_FLAGS;
        end else begin
            flg_q <= (flg_q & flg_keep) | flg_set;
            if (wr_flg) begin
                flg_q[FL_COMB] <= wd[FL_COMB];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            swc1_q <= 1'b0;
            swc2_q <= 1'b0;
        end else begin
            swc1_q <= sw_cap1;
            swc2_q <= sw_cap2;
        end
    end

    // Masks; end of block clears the DMA enable even against a software set
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            msk_q <= RST_IRQ_DMA_MASKS;
        end else begin
            if (wr_msk) begin
                msk_q <= wd;
            end
            if (dma_in.eob_cap) begin
                msk_q[MK_CDMA] <= 1'b0;
            end
            if (dma_in.eob_cmp) begin
                msk_q[MK_MDMA] <= 1'b0;
            end
        end
    end

    // End-of-block interrupts stay pending until the core acknowledges the group
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            eob_cap_q <= 1'b0;
            eob_cmp_q <= 1'b0;
        end else begin
            eob_cap_q <= dma_in.eob_cap | (eob_cap_q & ~(irq_ack & (grp_q == GRP_CAP)));
            eob_cmp_q <= dma_in.eob_cmp | (eob_cmp_q & ~(irq_ack & (grp_q == GRP_CMP)));
        end
    end

    // Interrupt request and group code
    assign cap_src  = flg_q[FL_COMB] ? (flg_q[FL_CAP1] & flg_q[FL_CAP2])
                                     : (flg_q[FL_CAP1] | flg_q[FL_CAP2]);
    assign cmp_src  = msk_q[MK_MDMA] ? eob_cmp_q : flg_q[FL_CMP1];
    assign cap_irq  = msk_q[MK_CIRQ] & (msk_q[MK_CDMA] ? eob_cap_q : cap_src);
    assign cmp_irq  = (msk_q[MK_M1IRQ] & cmp_src)
                    | (msk_q[MK_M2IRQ] & flg_q[FL_CMP2]);
    assign wrap_irq = msk_q[MK_WIRQ] & flg_q[FL_WRAP];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
            grp_q <= GRP_WRAP;
        end else begin
            irq_q <= msk_q[MK_GIE] & (cap_irq | cmp_irq | wrap_irq);
            if (cap_irq) begin
                grp_q <= GRP_CAP;
            end else if (cmp_irq) begin
                grp_q <= GRP_CMP;
            end else if (wrap_irq) begin
                grp_q <= GRP_WRAP;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            vbase_q <= RST_VECTOR_BASE;
        end else if (wr_vec) begin
            vbase_q <= wd[7:3];
        end
    end

    // DMA requests and pointer registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dreq_cap_q <= 1'b0;
            dreq_cmp_q <= 1'b0;
        end else begin
            dreq_cap_q <= evt.cap1 & msk_q[MK_CDMA];
            dreq_cmp_q <= evt.cmp1 & msk_q[MK_MDMA];
        end
    end

    // Direction bit is hardware-owned; software writes to it are dropped
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dcp_q <= RST_DMA_COUNT_PTR;
            dap_q <= RST_DMA_ADDR_PTR;
        end else begin
            if (wr_dcp) begin
                dcp_q[7:DP_SWAP] <= wd[7:DP_SWAP];
                dcp_q[DP_SEL]    <= wd[DP_SEL];
            end
            if (wr_dap) begin
                dap_q[7:DP_SWAP] <= wd[7:DP_SWAP];
                dap_q[DP_SEL]    <= wd[DP_SEL];
            end
            if (dma_in.eob_cmp & dma_in.swap_en) begin
                dcp_q[DP_SWAP] <= ~dcp_q[DP_SWAP];
                dap_q[DP_SWAP] <= ~dap_q[DP_SWAP];
            end
            if (evt.cap1 & msk_q[MK_CDMA]) begin
                dcp_q[DP_DIR] <= 1'b0;
                dap_q[DP_DIR] <= 1'b0;
            end else if (evt.cmp1 & msk_q[MK_MDMA]) begin
                dcp_q[DP_DIR] <= 1'b1;
                dap_q[DP_DIR] <= 1'b1;
            end
        end
    end

    assign avs_readdata          = rdata_q;
    assign avs_waitrequest       = wait_q;
    assign output_pin_b          = pin_q;
    assign chip_event_pulse      = evp_q;
    assign irq_req               = irq_q;
    assign irq_vector            = {vbase_q, grp_q, 1'b0};
    assign sw_capture1_pulse     = swc1_q;
    assign sw_capture2_pulse     = swc2_q;
    assign dma_out.cap_req       = dreq_cap_q;
    assign dma_out.cmp_req       = dreq_cmp_q;
    assign dma_out.count_ptr     = dcp_q;
    assign dma_out.addr_ptr      = dap_q;
    assign dma_out.regfile       = dcp_q[DP_SEL];
    // Segment choice only matters for memory DMA
    assign dma_out.use_dma_seg   = dap_q[DP_SEL];
    assign dma_out.table_sel     = dap_q[DP_SWAP];

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_cmp1_alone;
        evt.cmp1 && !evt.cmp2 && !evt.wrap;
    endsequence
    sequence s_both_cmp_and;
        evt.cmp1 && evt.cmp2 && !evt.wrap
            && obc_q[OB_C0_LO+:2] == ACT_TOGGLE && obc_q[OB_C1_LO+:2] == ACT_CLEAR;
    endsequence

    property p_cmp1_set;
        s_cmp1_alone and (obc_q[OB_C0_LO+:2] == ACT_SET) |=> output_pin_b;
    endproperty
    a_cmp1_set: assert property (p_cmp1_set) else $error("pin b not set on first compare");

    property p_cmp2_toggle;
        !evt.cmp1 && evt.cmp2 && !evt.wrap && obc_q[OB_C1_LO+:2] == ACT_TOGGLE
            |=> output_pin_b != $past(output_pin_b);
    endproperty
    a_cmp2_toggle: assert property (p_cmp2_toggle) else $error("pin b not toggled on second compare");

    property p_wrap_clear;
        !evt.cmp1 && !evt.cmp2 && evt.wrap && obc_q[OB_WR_LO+:2] == ACT_CLEAR |=> !output_pin_b;
    endproperty
    a_wrap_clear: assert property (p_wrap_clear) else $error("pin b not cleared on wrap");

    property p_and_codes;
        s_both_cmp_and |=> output_pin_b;
    endproperty
    a_and_codes: assert property (p_and_codes) else $error("coinciding actions not anded");

    property p_event_pulse;
        evt.wrap && obc_q[OB_OEV] ##1 !evt.wrap |-> chip_event_pulse ##1 !chip_event_pulse;
    endproperty
    a_event_pulse: assert property (p_event_pulse) else $error("event pulse not one cycle");

    property p_cap1_flag;
        evt.cap1 |=> flg_q[FL_CAP1];
    endproperty
    a_cap1_flag: assert property (p_cap1_flag) else $error("first capture flag not set");

    property p_cap_overrun;
        evt.cap1 && flg_q[FL_CAP1] |=> flg_q[FL_OCAP] [*2];
    endproperty
    a_cap_overrun: assert property (p_cap_overrun) else $error("capture overrun missed");

    property p_global_off;
        !msk_q[MK_GIE] |=> !irq_req;
    endproperty
    a_global_off: assert property (p_global_off) else $error("interrupt with global enable off");

    property p_eob_cap;
        dma_in.eob_cap |=> !msk_q[MK_CDMA] && eob_cap_q;
    endproperty
    a_eob_cap: assert property (p_eob_cap) else $error("capture dma mask not cleared");

    property p_vector_low;
        $changed(grp_q) |-> irq_vector[0] == 1'b0 && irq_vector[2:1] != 2'b01;
    endproperty
    a_vector_low: assert property (p_vector_low) else $error("vector low bits wrong");
endmodule

// *** tev_ctrl_tb.sv ***
// Self-checking bench of the timer event control block
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tev_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tev_pkg::*;
    logic              ref_clk = 1'b0;
    logic              rstn = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [3:0]        avs_byteenable = 4'h1;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    tev_evt_s          evt;
    tev_dma_in_s       dma_in;
    logic              irq_ack;
    logic              bicapture_mode = 1'b0;
    logic              output_pin_b;
    logic              chip_event_pulse;
    logic              irq_req;
    logic [7:0]        irq_vector;
    logic              sw_capture1_pulse;
    logic              sw_capture2_pulse;
    tev_dma_out_s      dma_out;
    int                fail_count = 0;
    int                n_compared = 0;
    logic [7:0]        d;

    always #10 ref_clk = ~ref_clk;

    tev_core_model u_tev_core_model (.ref_clk(ref_clk), .evt(evt), .dma_in(dma_in), .irq_ack(irq_ack));

    tev_ctrl u_tev_ctrl (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .evt(evt),
        .bicapture_mode(bicapture_mode), .dma_in(dma_in), .irq_ack(irq_ack), .output_pin_b(output_pin_b),
        .chip_event_pulse(chip_event_pulse), .irq_req(irq_req), .irq_vector(irq_vector),
        .sw_capture1_pulse(sw_capture1_pulse), .sw_capture2_pulse(sw_capture2_pulse), .dma_out(dma_out));

    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // One Avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int k;
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, wd};
        avs_write <= wr;
        avs_read <= !wr;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 50) begin
            fail_count++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [7:0] x;
        bus(1'b1, idx, v, x);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    function automatic logic act(input logic [1:0] c, input logic p);
        return c == ACT_SET ? 1'b1 : c == ACT_TOGGLE ? !p : c == ACT_CLEAR ? 1'b0 : p;
    endfunction

    task automatic t_reset;
        logic [7:0] idx[7] = '{IDX_DMA_COUNT_PTR, IDX_DMA_ADDR_PTR, IDX_VECTOR_BASE, IDX_OUTB_ACTION,
                               IDX_EVENT_FLAGS, IDX_IRQ_DMA_MASKS, 8'h00};
        wr(8'h00, 8'h5a);
        foreach (idx[i]) begin
            bus(1'b0, idx[i], 8'h00, d);
            `CHK("reset_value", 8'h00, d)
        end
        $display("test reset done");
    endtask

    // Every action code of every source, from both pin levels
    task automatic t_pin;
        int lo[3] = '{OB_C0_LO, OB_C1_LO, OB_WR_LO};
        tev_evt_s ev[3] = '{5'b00100, 5'b00010, 5'b00001};
        logic [7:0] cfg;
        logic e;
        for (int f = 0; f < 3; f++)
            for (int c = 0; c < 4; c++)
                for (int p = 0; p < 2; p++) begin
                    cfg = 8'hfc;
                    cfg[lo[f]+:2] = c[1:0];
                    cfg[0] = p[0];
                    wr(IDX_OUTB_ACTION, cfg);
                    u_tev_core_model.fire(ev[f]);
                    cyc(2);
                    e = act(c[1:0], p[0]);
                    `CHK("pin_b", e, output_pin_b)
                    bus(1'b0, IDX_OUTB_ACTION, 8'h00, d);
                    `CHK("preset_readback", e, d[OB_PRE])
                end
        wr(IDX_OUTB_ACTION, 8'h60);
        u_tev_core_model.fire(5'b00110);
        cyc(2);
        `CHK("pin_b_and", 1'b1, output_pin_b)
        $display("test pin done");
    endtask

    task automatic t_pulse;
        wr(IDX_OUTB_ACTION, 8'hfe);
        u_tev_core_model.fire(5'b00001);
        #1;
        `CHK("event_pulse", 1'b1, chip_event_pulse)
        cyc(1);
        `CHK("event_pulse_end", 1'b0, chip_event_pulse)
        wr(IDX_OUTB_ACTION, 8'hfc);
        u_tev_core_model.fire(5'b00001);
        #1;
        `CHK("event_pulse_off", 1'b0, chip_event_pulse)
        $display("test pulse done");
    endtask

    task automatic t_irq;
        wr(IDX_EVENT_FLAGS, 8'h00);
        wr(IDX_IRQ_DMA_MASKS, 8'h07);
        u_tev_core_model.fire(5'b00100);
        cyc(3);
        `CHK("irq_gated", 1'b0, irq_req)
        wr(IDX_IRQ_DMA_MASKS, 8'h84);
        cyc(3);
        `CHK("irq_cmp1", 1'b1, irq_req)
        `CHK("group_cmp", 2'b11, irq_vector[2:1])
        u_tev_core_model.fire(5'b00100);
        cyc(3);
        bus(1'b0, IDX_EVENT_FLAGS, 8'h00, d);
        `CHK("cmp_overrun", 2'b11, {d[FL_CMP1], d[FL_OCMP]})
        wr(IDX_EVENT_FLAGS, 8'h00);
        cyc(3);
        `CHK("irq_cleared", 1'b0, irq_req)
        wr(IDX_IRQ_DMA_MASKS, 8'h82);
        u_tev_core_model.fire(5'b00010);
        cyc(3);
        `CHK("irq_cmp2", 1'b1, irq_req)
        wr(IDX_EVENT_FLAGS, 8'h00);
        wr(IDX_IRQ_DMA_MASKS, 8'h81);
        u_tev_core_model.fire(5'b00001);
        cyc(3);
        `CHK("irq_wrap", 1'b1, irq_req)
        `CHK("group_wrap", 2'b00, irq_vector[2:1])
        wr(IDX_EVENT_FLAGS, 8'h00);
        $display("test irq done");
    endtask

    task automatic t_swcap;
        wr(IDX_EVENT_FLAGS, 8'h80);
        #1;
        `CHK("sw_capture1", 1'b1, sw_capture1_pulse)
        bus(1'b0, IDX_EVENT_FLAGS, 8'h00, d);
        `CHK("cap_overrun", 2'b11, {d[FL_CAP1], d[FL_OCAP]})
        bicapture_mode <= 1'b1;
        wr(IDX_EVENT_FLAGS, 8'h40);
        #1;
        `CHK("sw_capture2_blocked", 1'b0, sw_capture2_pulse)
        bicapture_mode <= 1'b0;
        wr(IDX_EVENT_FLAGS, 8'h40);
        #1;
        `CHK("sw_capture2", 1'b1, sw_capture2_pulse)
        wr(IDX_EVENT_FLAGS, 8'h00);
        $display("test swcap done");
    endtask

    // Hardware captures: AND and OR combine, group code, overrun
    task automatic t_cap;
        wr(IDX_EVENT_FLAGS, 8'h01);
        wr(IDX_IRQ_DMA_MASKS, 8'ha0);
        u_tev_core_model.fire(5'b10000);
        cyc(3);
        `CHK("irq_cap_and_one", 1'b0, irq_req)
        u_tev_core_model.fire(5'b01000);
        cyc(3);
        `CHK("irq_cap_and_both", 1'b1, irq_req)
        `CHK("group_cap", 2'b10, irq_vector[2:1])
        u_tev_core_model.fire(5'b10000);
        bus(1'b0, IDX_EVENT_FLAGS, 8'h00, d);
        `CHK("cap_hw_overrun", 2'b11, {d[FL_CAP1], d[FL_OCAP]})
        wr(IDX_EVENT_FLAGS, 8'h00);
        cyc(3);
        `CHK("irq_cap_cleared", 1'b0, irq_req)
        u_tev_core_model.fire(5'b01000);
        cyc(3);
        `CHK("irq_cap_or", 1'b1, irq_req)
        wr(IDX_EVENT_FLAGS, 8'h00);
        wr(IDX_IRQ_DMA_MASKS, 8'h00);
        $display("test cap done");
    endtask

    task automatic t_dma;
        wr(IDX_IRQ_DMA_MASKS, 8'h40);
        u_tev_core_model.end_block(1'b1, 1'b0);
        cyc(2);
        bus(1'b0, IDX_IRQ_DMA_MASKS, 8'h00, d);
        `CHK("cap_dma_mask", 1'b0, d[MK_CDMA])
        wr(IDX_IRQ_DMA_MASKS, 8'h08);
        u_tev_core_model.end_block(1'b0, 1'b0);
        cyc(2);
        bus(1'b0, IDX_IRQ_DMA_MASKS, 8'h00, d);
        `CHK("cmp_dma_mask", 1'b0, d[MK_MDMA])
        wr(IDX_IRQ_DMA_MASKS, 8'h48);
        u_tev_core_model.fire(5'b00100);
        #1;
        `CHK("cmp_dma_req", 1'b1, dma_out.cmp_req)
        `CHK("dir_cmp", 2'b11, {dma_out.count_ptr[DP_DIR], dma_out.addr_ptr[DP_DIR]})
        u_tev_core_model.fire(5'b10000);
        #1;
        `CHK("cap_dma_req", 1'b1, dma_out.cap_req)
        `CHK("dir_cap", 2'b00, {dma_out.count_ptr[DP_DIR], dma_out.addr_ptr[DP_DIR]})
        wr(IDX_DMA_COUNT_PTR, 8'h01);
        wr(IDX_DMA_ADDR_PTR, 8'h05);
        u_tev_core_model.end_block(1'b0, 1'b1);
        #1;
        `CHK("count_ptr_swap", 8'h05, dma_out.count_ptr)
        `CHK("addr_ptr_swap", 8'h01, dma_out.addr_ptr)
        `CHK("table_sel", 1'b0, dma_out.table_sel)
        `CHK("regfile", 1'b1, dma_out.regfile)
        `CHK("use_dma_seg", 1'b1, dma_out.use_dma_seg)
        wr(IDX_IRQ_DMA_MASKS, 8'h8c);
        cyc(3);
        `CHK("irq_eob_cmp", 1'b1, irq_req)
        u_tev_core_model.ack();
        cyc(3);
        `CHK("irq_eob_acked", 1'b0, irq_req)
        wr(IDX_IRQ_DMA_MASKS, 8'h00);
        wr(IDX_VECTOR_BASE, 8'haf);
        bus(1'b0, IDX_VECTOR_BASE, 8'h00, d);
        `CHK("vector_base", 5'h15, d[7:3])
        `CHK("vector_bit0", 1'b0, d[0])
        avs_byteenable <= 4'h0;
        wr(IDX_VECTOR_BASE, 8'h00);
        avs_byteenable <= 4'h1;
        bus(1'b0, IDX_VECTOR_BASE, 8'h00, d);
        `CHK("vector_lane_off", 5'h15, d[7:3])
        $display("test dma done");
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_pin();
        t_pulse();
        t_irq();
        t_swcap();
        t_cap();
        t_dma();
        give_verdict();
    end
endmodule

// *** tev_pkg.sv ***
// Package: register map, field layout, action codes and carriers of the timer event block
package tev_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_DMA_COUNT_PTR  = 8'hf0;
    localparam logic [7:0] IDX_DMA_ADDR_PTR   = 8'hf1;
    localparam logic [7:0] IDX_VECTOR_BASE    = 8'hf2;
    localparam logic [7:0] IDX_OUTB_ACTION    = 8'hfd;
    localparam logic [7:0] IDX_EVENT_FLAGS    = 8'hfe;
    localparam logic [7:0] IDX_IRQ_DMA_MASKS  = 8'hff;
    localparam int         ADDR_W             = 10;
    localparam int         DATA_W             = 32;

    // Reset values
    localparam logic [7:0] RST_DMA_COUNT_PTR  = 8'h00;
    localparam logic [7:0] RST_DMA_ADDR_PTR   = 8'h00;
    localparam logic [4:0] RST_VECTOR_BASE    = 5'h00;
    localparam logic [7:0] RST_OUTB_ACTION    = 8'h00;
    localparam logic [7:0] RST_EVENT_FLAGS    = 8'h00;
    localparam logic [7:0] RST_IRQ_DMA_MASKS  = 8'h00;

    // Output B action register fields
    localparam int OB_C0_LO = 6;
    localparam int OB_C1_LO = 4;
    localparam int OB_WR_LO = 2;
    localparam int OB_OEV   = 1;
    localparam int OB_PRE   = 0;

    // Flag register fields
    localparam int FL_CAP1  = 7;
    localparam int FL_CAP2  = 6;
    localparam int FL_CMP1  = 5;
    localparam int FL_CMP2  = 4;
    localparam int FL_WRAP  = 3;
    localparam int FL_OCAP  = 2;
    localparam int FL_OCMP  = 1;
    localparam int FL_COMB  = 0;

    // Mask register fields
    localparam int MK_GIE   = 7;
    localparam int MK_CDMA  = 6;
    localparam int MK_CIRQ  = 5;
    localparam int MK_C2IRQ = 4;
    localparam int MK_MDMA  = 3;
    localparam int MK_M1IRQ = 2;
    localparam int MK_M2IRQ = 1;
    localparam int MK_WIRQ  = 0;

    // DMA pointer fields
    localparam int DP_SWAP  = 2;
    localparam int DP_DIR   = 1;
    localparam int DP_SEL   = 0;

    // Pin actions
    localparam logic [1:0] ACT_SET    = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_NOP    = 2'h3;

    typedef enum logic [1:0] {
        GRP_WRAP = 2'b00,
        GRP_CAP  = 2'b10,
        GRP_CMP  = 2'b11
    } tev_grp_e;

    typedef struct packed {
        logic cap1;
        logic cap2;
        logic cmp1;
        logic cmp2;
        logic wrap;
    } tev_evt_s;

    typedef struct packed {
        logic eob_cap;
        logic eob_cmp;
        logic swap_en;
    } tev_dma_in_s;

    typedef struct packed {
        logic       cap_req;
        logic       cmp_req;
        logic [7:0] count_ptr;
        logic [7:0] addr_ptr;
        logic       regfile;
        logic       use_dma_seg;
        logic       table_sel;
    } tev_dma_out_s;
endpackage
